//--- photon_tt_defines.svh
// Purpose: constants of the photon time-tag record encoder
// Assumes: included by bare name
// Notes: definitions only
`ifndef PHOTON_TT_DEFINES_SVH
`define PHOTON_TT_DEFINES_SVH
`define REC_W 32
`define BYTE_W 8
`define LAST_BYTE 2'h3
`define TIME_W 54
`define TLO_W 24
`define HI_W 30
`define CH_W 5
`define TYPE_EVENT 2'h0
`define TYPE_HIGH 2'h1
`define TYPE_RSVD 2'h2
`define TYPE_DESC 2'h3
`define DESC_MID 3'h0
`define DESC_B25 1'h0
`define DESC_B24 1'h1
`define LOSS_BIT 29
`define CH_HI 28
`define CH_LO 24
`define UPPER_RST 30'h0
`define FIFO_DEPTH 16
`endif

//--- photon_tt_pkg.sv
// Purpose: types of the photon time-tag record encoder
// Assumes: nothing
// Notes: states only
`default_nettype none
package photon_tt_pkg;
  typedef enum logic [1:0] {st_desc, st_run, st_high} st_t;
endpackage
`default_nettype wire

//--- record_fifo.sv
// Purpose: record buffer between encoder and byte serialiser
// Assumes: one clock, enable freezes all state
// Notes: depth must be a power of two
`timescale 1ns/1ns
`default_nettype none
module record_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [W-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [W-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic wr_go;
  logic rd_go;

  assign o_wr_ready = (cnt_r != DEPTH[AW:0]);
  assign o_rd_valid = (cnt_r != '0);
  assign o_rd_data = mem[rp_r];
  assign wr_go = i_ce && i_wr_valid && o_wr_ready;
  assign rd_go = i_ce && o_rd_valid && i_rd_ready;

  always_ff @(posedge i_clk_sys) begin
    if (wr_go) begin
      mem[wp_r] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (wr_go) begin
        wp_r <= wp_r + 1'b1;
      end
      if (rd_go) begin
        rp_r <= rp_r + 1'b1;
      end
      if (wr_go && !rd_go) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (rd_go && !wr_go) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // record_fifo
`default_nettype wire

//--- photon_time_tag_record_encoder.sv
// Purpose: turn photon events into a byte stream of 32-bit time-tag records
// Assumes: event inputs synchronous to i_clk_sys, times already 54-bit absolute
// Notes: a 16-word record fifo decouples the encoder from the byte sink
`timescale 1ns/1ns
`default_nettype none
`include "photon_tt_defines.svh"

// What this block does
// [RQ1] 32-bit records, four bytes, low byte first
// [RQ2] descriptor record opens every stream
// [RQ3] descriptor bits 11000, raw, 0, 1
// [RQ4] raw flag one for unprocessed pass-through
// [RQ5] descriptor low 24 bits hold time unit
// [RQ6] events carry channel and 54-bit timestamp
// [RQ7] events normally carry only low 24 bits
// [RQ8] bits 31:30 give the record type
// [RQ9] event: loss bit, channel, low time
// [RQ10] channel numbers passed on as numbered upstream
// [RQ11] loss flag on first event after overflow
// [RQ12] high-time record on upper part change
// [RQ13] high-time record follows its event directly
// [RQ14] preprocessing reorders, never drops photons
// [RQ15] raw stream marks converter clock overflows
// [RQ16] no reserved type, descriptor only once
// [RQ17] reset clears upper, loss, restarts descriptor
module photon_time_tag_record_encoder
  import photon_tt_pkg::*;
#(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_raw_mode,
  input wire logic [`TLO_W-1:0] i_time_unit_fs,
  input wire logic i_ev_valid,
  output logic o_ev_ready,
  input wire logic [`CH_W-1:0] i_ev_channel,
  input wire logic [`TIME_W-1:0] i_ev_time,
  input wire logic i_ev_overflow,
  input wire logic i_clk_wrap,
  output logic o_byte_valid,
  input wire logic i_byte_ready,
  output logic [`BYTE_W-1:0] o_byte
);
  st_t st_r;
  logic raw_r;
  logic seen_r;
  logic [`HI_W-1:0] upper_r;
  logic loss_pend_r;
  logic wrap_pend_r;
  logic held_v_r;
  logic [`CH_W-1:0] held_ch_r;
  logic [`TIME_W-1:0] held_time_r;

  logic wr_v;
  logic [`REC_W-1:0] wr_data;
  logic fi_rdy;
  logic go;
  logic take;
  logic emit;
  logic mark;
  logic in_first;
  logic [`CH_W-1:0] ev_ch;
  logic [`TIME_W-1:0] ev_time;
  logic ev_fire;
  logic up_change;

  logic fo_v;
  logic fo_rdy;
  logic [`REC_W-1:0] fo_data;
  logic [`REC_W-1:0] word_r;
  logic [1:0] cnt_r;
  logic busy_r;

  assign go = i_ce && fi_rdy;
  assign o_ev_ready = go && (st_r == st_run) && !(raw_r && wrap_pend_r);
  assign take = i_ev_valid && o_ev_ready;
  assign in_first = i_ev_time < held_time_r;
  assign ev_fire = emit && go;
  assign up_change = (ev_time[`TIME_W-1:`TLO_W] != upper_r);

  // record selection; processed mode keeps one event back so a pair that
  // arrives out of order from separate converter fifos is swapped
  always_comb begin
    wr_v = 1'b0;
    wr_data = '0;
    emit = 1'b0;
    mark = 1'b0;
    ev_ch = i_ev_channel;
    ev_time = i_ev_time;
    case (st_r)
      st_desc: begin
        wr_v = 1'b1;
        wr_data = {`TYPE_DESC, `DESC_MID, i_raw_mode, `DESC_B25, `DESC_B24, // RQ3 RQ4
                   i_time_unit_fs}; // RQ5
      end
      st_high: begin
        wr_v = 1'b1;
        wr_data = {`TYPE_HIGH, upper_r}; // RQ8 RQ12
      end
      st_run: begin
        if (raw_r && wrap_pend_r) begin
          mark = 1'b1;
          wr_v = 1'b1;
          wr_data = {`TYPE_HIGH, upper_r}; // RQ15
        end else if (raw_r) begin
          emit = i_ev_valid;
        end else if (i_ev_valid && held_v_r) begin
          emit = 1'b1; // RQ14
          if (!in_first) begin
            ev_ch = held_ch_r;
            ev_time = held_time_r;
          end
        end else if (!i_ev_valid && held_v_r) begin
          emit = 1'b1; // RQ14
          ev_ch = held_ch_r;
          ev_time = held_time_r;
        end
        if (emit) begin
          wr_v = 1'b1;
          wr_data = {`TYPE_EVENT, loss_pend_r, ev_ch, // RQ9 RQ10 RQ11
                     ev_time[`TLO_W-1:0]}; // RQ7
        end
      end
      default: begin
        wr_v = 1'b0;
      end
    endcase
  end

  // stream sequencing: descriptor once, high-time right after its event
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= st_desc; // RQ17
      raw_r <= 1'b0;
    end else if (go) begin
      case (st_r)
        st_desc: begin
          st_r <= st_run; // RQ2 RQ16
          raw_r <= i_raw_mode;
        end
        st_run: begin
          if (emit && up_change) begin
            st_r <= st_high; // RQ13
          end
        end
        st_high: begin
          st_r <= st_run;
        end
        default: begin
          st_r <= st_desc;
        end
      endcase
    end
  end

  // upper 30 bits of the 54-bit time as last announced downstream
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      upper_r <= `UPPER_RST; // RQ17
    end else if (ev_fire && up_change) begin
      upper_r <= ev_time[`TIME_W-1:`TLO_W]; // RQ6 RQ12
    end
  end

  // a new overflow beats the clear so no loss report is dropped
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      loss_pend_r <= 1'b0; // RQ17
    end else if (i_ce) begin
      if (i_ev_overflow) begin
        loss_pend_r <= 1'b1; // RQ11
      end else if (ev_fire) begin
        loss_pend_r <= 1'b0;
      end
    end
  end

  // converter clock wraps are only marked in the raw stream
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      wrap_pend_r <= 1'b0;
    end else if (i_ce) begin
      if (i_clk_wrap && raw_r) begin
        wrap_pend_r <= 1'b1; // RQ15
      end else if (mark && go) begin
        wrap_pend_r <= 1'b0;
      end
    end
  end

  // hold slot; limitation: only neighbours can be swapped
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      held_v_r <= 1'b0;
      held_ch_r <= '0;
      held_time_r <= '0;
    end else if (!raw_r && go && st_r == st_run) begin
      if (take && (!held_v_r || !in_first)) begin
        held_v_r <= 1'b1; // RQ14
        held_ch_r <= i_ev_channel;
        held_time_r <= i_ev_time;
      end else if (!take && held_v_r) begin
        held_v_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      seen_r <= 1'b0;
    end else if (go && wr_v) begin
      seen_r <= 1'b1;
    end
  end

  record_fifo #(
    .W(`REC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_wr_valid(wr_v),
    .o_wr_ready(fi_rdy),
    .i_wr_data(wr_data),
    .o_rd_valid(fo_v),
    .i_rd_ready(fo_rdy),
    .o_rd_data(fo_data)
  );

  // byte serialiser; next word loads on the last byte for full rate
  assign fo_rdy = !busy_r || (cnt_r == `LAST_BYTE && i_byte_ready);
  assign o_byte_valid = busy_r;
  assign o_byte = word_r[`BYTE_W-1:0];

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      word_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
    end else if (i_ce) begin
      if (fo_v && fo_rdy) begin
        word_r <= fo_data;
        cnt_r <= '0;
        busy_r <= 1'b1;
      end else if (busy_r && i_byte_ready) begin
        word_r <= {{`BYTE_W{1'b0}}, word_r[`REC_W-1:`BYTE_W]}; // RQ1
        cnt_r <= cnt_r + 1'b1;
        if (cnt_r == `LAST_BYTE) begin
          busy_r <= 1'b0;
        end
      end
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);

  a_first_desc: assert property ( // RQ2
    (go && wr_v && !seen_r) |-> (wr_data[31:30] == `TYPE_DESC))
    else $error("first record is not a descriptor");

  a_desc_once: assert property ( // RQ16
    (go && wr_v && seen_r) |-> (wr_data[31:30] != `TYPE_DESC))
    else $error("descriptor repeated");

  a_no_reserved: assert property ( // RQ8
    (go && wr_v) |-> (wr_data[31:30] != `TYPE_RSVD))
    else $error("reserved record type written");

  a_desc_fields: assert property ( // RQ3
    (go && wr_v && st_r == st_desc) |-> (wr_data[29:27] == 3'h0 && wr_data[25:24] == 2'h1
      && wr_data[26] == i_raw_mode && wr_data[23:0] == i_time_unit_fs) ##1 (raw_r == $past(i_raw_mode)))
    else $error("descriptor fields wrong");

  a_high_after_event: assert property ( // RQ13
    (ev_fire && up_change) |=> (st_r == st_high && upper_r == $past(ev_time[53:24])))
    else $error("high-time record not next after event");

  a_high_payload: assert property ( // RQ12
    (go && st_r == st_high) |-> (wr_data == {2'h1, upper_r}) ##1 (st_r == st_run))
    else $error("high-time record payload wrong");

  a_loss_flag: assert property ( // RQ11
    (i_ce && i_ev_overflow) |=> (loss_pend_r throughout (!ev_fire [*1]))
      or (ev_fire && wr_data[29]))
    else $error("loss not reported on next event");

  a_event_fields: assert property ( // RQ9
    ev_fire |-> (wr_data[28:24] == ev_ch && wr_data[23:0] == ev_time[23:0]
      && wr_data[29] == loss_pend_r))
    else $error("event record fields wrong");

  a_no_drop: assert property ( // RQ14
    (take && !raw_r && held_v_r) |-> ev_fire ##1 held_v_r)
    else $error("photon dropped in reorder slot");

  a_byte_order: assert property ( // RQ1
    (i_ce && fo_v && fo_rdy) |=> (o_byte_valid && o_byte == $past(fo_data[7:0]) && cnt_r == 2'h0))
    else $error("record not started with low byte");

  a_wrap_marker: assert property ( // RQ15
    (go && st_r == st_run && raw_r && wrap_pend_r) |-> (!o_ev_ready && wr_v && wr_data == {`TYPE_HIGH, upper_r}))
    else $error("clock wrap marker wrong");

  a_loss_set_wins: assert property ( // RQ11
    (i_ce && i_ev_overflow) |=> loss_pend_r)
    else $error("overflow not held as pending loss");
endmodule // photon_time_tag_record_encoder
`default_nettype wire

//--- record_sink.sv
// Purpose: byte sink on the far side, packs bytes back into records
// Assumes: byte taken on valid, ready and clock enable at a rising edge
// Notes: ready is paced one cycle in four off so the serialiser sees slow answers
`timescale 1ns/1ns
`default_nettype none
module record_sink (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic [7:0] i_byte,
  output logic o_ready
);
  logic [31:0] got[$];
  logic [31:0] acc_r;
  logic [31:0] word;
  logic [1:0] idx_r;
  logic [1:0] pace_r;

  always @(negedge i_clk_sys) begin
    pace_r <= (i_nrst) ? pace_r + 2'h1 : 2'h0;
    o_ready <= !i_stall && (pace_r != 2'h0);
  end

  // low byte first, four bytes make one record
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      idx_r <= 2'h0;
      acc_r <= 32'h0;
    end else if (i_valid && o_ready && i_ce) begin
      word = acc_r;
      word[8*idx_r +: 8] = i_byte;
      acc_r <= word;
      if (idx_r == 2'h3) begin
        got.push_back(word);
      end
      idx_r <= idx_r + 2'h1;
    end
  end
endmodule // record_sink
`default_nettype wire

//--- photon_time_tag_record_encoder_test.sv
// Purpose: self-checking bench of the time-tag record encoder
// Assumes: inputs change at the falling edge
// Notes: expected records are queued and compared against the sink
`timescale 1ns/1ns
`default_nettype none
`include "photon_tt_defines.svh"
module photon_time_tag_record_encoder_test;
  logic clk, nrst, ce, raw, ev_valid, ev_ovf, wrap, stall;
  logic ev_ready, byte_valid, byte_ready;
  logic [23:0] tu;
  logic [4:0] ch;
  logic [53:0] tm;
  logic [7:0] bytev;
  logic [31:0] exp_q[$];
  int mismatches, checks_done, refused;
  logic [4:0] chl[5] = '{5'h01, 5'h02, 5'h0B, 5'h0C, 5'h10};

  photon_time_tag_record_encoder #(.FIFO_DEPTH(16)) u_dut (.i_clk_sys(clk), .i_nrst(nrst), .i_ce(ce),
    .i_raw_mode(raw), .i_time_unit_fs(tu), .i_ev_valid(ev_valid), .o_ev_ready(ev_ready),
    .i_ev_channel(ch), .i_ev_time(tm), .i_ev_overflow(ev_ovf), .i_clk_wrap(wrap),
    .o_byte_valid(byte_valid), .i_byte_ready(byte_ready), .o_byte(bytev));
  record_sink u_sink (.i_clk_sys(clk), .i_nrst(nrst), .i_ce(ce), .i_stall(stall), .i_valid(byte_valid),
    .i_byte(bytev), .o_ready(byte_ready));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] evw(input logic l, input logic [4:0] c, input logic [53:0] t);
    return {`TYPE_EVENT, l, c, t[23:0]};
  endfunction

  task automatic complete_run;
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic fail(input logic [31:0] g, input logic [31:0] e);
    mismatches++;
    $display("[FAIL] %0t got %h exp %h", $time, g, e);
  endtask

  task automatic do_reset(input logic r);
    @(negedge clk);
    nrst = 1'b0;
    raw = r;
    repeat (16) @(negedge clk);
    u_sink.got.delete();
    nrst = 1'b1;
  endtask

  // valid stays up so back-to-back calls offer one event per cycle
  // ready is read 1 ns after the falling edge so an enable change there is seen
  task automatic ev(input logic [4:0] c, input logic [53:0] t);
    int n;
    ev_valid = 1'b1;
    ch = c;
    tm = t;
    #1;
    for (n = 0; !ev_ready && n < 1000; n++) begin
      refused++;
      @(negedge clk);
      #1;
    end
    if (n >= 1000) fail(32'h0, 32'h1);
    @(negedge clk);
  endtask

  task automatic idle;
    ev_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  task automatic pulse_ovf;
    ev_ovf = 1'b1;
    @(negedge clk);
    ev_ovf = 1'b0;
  endtask

  // compare every queued record, then make sure nothing extra follows
  task automatic chk_q;
    int n;
    for (n = 0; n < 3000 && u_sink.got.size() < exp_q.size(); n++) @(negedge clk);
    while (exp_q.size() > 0) begin
      checks_done++;
      if (u_sink.got.size() == 0) fail(32'h0, exp_q[0]);
      else if (u_sink.got[0] !== exp_q[0]) fail(u_sink.got[0], exp_q[0]);
      if (u_sink.got.size() > 0) void'(u_sink.got.pop_front());
      void'(exp_q.pop_front());
    end
    repeat (20) @(negedge clk);
    checks_done++;
    if (u_sink.got.size() != 0) fail(u_sink.got[0], 32'h0);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    complete_run;
  end

  initial begin
    nrst = 1'b0; ce = 1'b1; raw = 1'b0; tu = 24'hABCDEF; ev_valid = 1'b0; ev_ovf = 1'b0;
    wrap = 1'b0; stall = 1'b0; ch = 5'h00; tm = 54'h0; mismatches = 0; checks_done = 0; refused = 0;
    do_reset(1'b0);
    exp_q.push_back({`TYPE_DESC, 3'h0, 1'b0, 1'b0, 1'b1, tu});
    chk_q;
    // a wrap in processed mode must add no record
    wrap = 1'b1;
    @(negedge clk);
    wrap = 1'b0;
    ev(5'h03, 54'h14);
    ev(5'h04, 54'h0A);
    idle;
    exp_q.push_back(evw(1'b0, 5'h04, 54'h0A));
    exp_q.push_back(evw(1'b0, 5'h03, 54'h14));
    chk_q;
    foreach (chl[i]) ev(chl[i], 54'h100 + i);
    idle;
    foreach (chl[i]) exp_q.push_back(evw(1'b0, chl[i], 54'h100 + i));
    chk_q;
    pulse_ovf;
    ev(5'h09, 54'h40);
    ev(5'h09, 54'h41);
    idle;
    exp_q.push_back(evw(1'b1, 5'h09, 54'h40));
    exp_q.push_back(evw(1'b0, 5'h09, 54'h41));
    chk_q;
    ev(5'h02, {30'h0000_0005, 24'h000007});
    idle;
    ev(5'h02, {30'h0000_0005, 24'h000009});
    idle;
    exp_q.push_back(evw(1'b0, 5'h02, 54'h7));
    exp_q.push_back({`TYPE_HIGH, 30'h0000_0005});
    exp_q.push_back(evw(1'b0, 5'h02, 54'h9));
    chk_q;
    // pending loss and upper part must not survive a reset
    pulse_ovf;
    tu = 24'h5A0F3C;
    do_reset(1'b1);
    exp_q.push_back({`TYPE_DESC, 3'h0, 1'b1, 1'b0, 1'b1, tu});
    ev(5'h07, 54'h33);
    idle;
    exp_q.push_back(evw(1'b0, 5'h07, 54'h33));
    wrap = 1'b1;
    @(negedge clk);
    wrap = 1'b0;
    exp_q.push_back({`TYPE_HIGH, 30'h0});
    chk_q;
    // overflow in the cycle an event is written: set wins, next event carries it
    ev_ovf = 1'b1;
    ev(5'h05, 54'h34);
    ev_ovf = 1'b0;
    ev(5'h06, 54'h35);
    idle;
    exp_q.push_back(evw(1'b0, 5'h05, 54'h34));
    exp_q.push_back(evw(1'b1, 5'h06, 54'h35));
    chk_q;
    stall = 1'b1;
    refused = 0;
    fork
      begin
        repeat (200) @(negedge clk);
        stall = 1'b0;
        repeat (3) @(negedge clk);
        ce = 1'b0;
        repeat (6) @(negedge clk);
        ce = 1'b1;
      end
    join_none
    for (int i = 0; i < 20; i++) ev(5'h01, 54'h200 + i);
    idle;
    for (int i = 0; i < 20; i++) exp_q.push_back(evw(1'b0, 5'h01, 54'h200 + i));
    chk_q;
    checks_done++;
    if (refused == 0) fail(32'h0, 32'h1);
    complete_run;
  end
endmodule // photon_time_tag_record_encoder_test
`default_nettype wire
